// ---- logic/simd_datapath.sv ----
// Packed integer vector execution unit with one registered stage.
// Assumes the issuing pipeline holds no back-pressure: every valid
// request gives a result exactly one clock later.
//
// Functional notes
// - shuffle index uses low three or four bits
// - control byte top bit zeroes result byte
// - shuffle control operand is never modified
// - negate destination where source element is negative
// - align right slices destination-over-source at immediate
// - low dword multiply keeps low 32 bits
// - wide dword multiply returns full signed products
// - word blend picks source where immediate bit set
// - byte blend selects by implied mask register
// - signed and unsigned element min and max
// - insert byte, dword or qword into lane
// - extract byte to qword lane to scalar
// - sign or zero extend packed narrow integers
// - eight sums over 4-byte groups
// - find smallest of eight unsigned words, index
// - value and index packed into low dword
// - zero flag when destination AND mask zero
// - carry flag when inverted mask AND destination zero
// - qword lanes compared for equality independently
// - dword to word pack with unsigned saturation
// - signed qword greater-than compare per lane
`default_nettype none

module simd_datapath (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Issue side
    input wire logic req_valid,
    input wire simd_pkg::req_t req,
    // Result side
    output logic rsp_valid,
    output var simd_pkg::rsp_t rsp
);
    import simd_pkg::*;

    // ----------------------------------------------------------------
    // Element helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] elem_mask(logic [1:0] sz);
        case (sz)
            SZ_BYTE: return 32'h000000FF;
            SZ_WORD: return 32'h0000FFFF;
            default: return 32'hFFFFFFFF;
        endcase
    endfunction

    // Element e of size sz, widened to 33 bits so unsigned dwords fit
    function automatic logic signed [32:0] get_elem(vec_t v, int e,
            logic [1:0] sz, logic sgn);
        logic [31:0] raw;
        logic [32:0] x;
        raw = 32'(v >> (e << (3 + int'(sz))));
        case (sz)
            SZ_BYTE: x = {{25{sgn & raw[7]}}, raw[7:0]};
            SZ_WORD: x = {{17{sgn & raw[15]}}, raw[15:0]};
            default: x = {sgn & raw[31], raw};
        endcase
        return $signed(x);
    endfunction

    function automatic vec_t put_elem(vec_t r, int e, logic [1:0] sz,
            logic [31:0] val);
        vec_t lane;
        lane = vec_t'(val & elem_mask(sz));
        return r | (lane << (e << (3 + int'(sz))));
    endfunction

    // Negate by sign of source; zero source gives zero
    function automatic vec_t cond_neg(vec_t d, vec_t s, logic [1:0] sz);
        vec_t r;
        logic signed [32:0] de;
        logic signed [32:0] se;
        logic signed [32:0] re;
        r = '0;
        for (int e = 0; e < (16 >> sz); e++) begin
            de = get_elem(d, e, sz, 1'b1);
            se = get_elem(s, e, sz, 1'b1);
            if (se < 0) begin
                re = -de;
            end else if (se == 0) begin
                re = '0;
            end else begin
                re = de;
            end
            r = put_elem(r, e, sz, re[31:0]);
        end
        return r;
    endfunction

    function automatic vec_t min_max(vec_t d, vec_t s, logic [1:0] sz,
            logic sgn, logic pick_max);
        vec_t r;
        logic signed [32:0] de;
        logic signed [32:0] se;
        logic take_src;
        r = '0;
        for (int e = 0; e < (16 >> sz); e++) begin
            de = get_elem(d, e, sz, sgn);
            se = get_elem(s, e, sz, sgn);
            take_src = pick_max ? (se > de) : (se < de);
            r = put_elem(r, e, sz, take_src ? se[31:0] : de[31:0]);
        end
        return r;
    endfunction

    // Bit-wise gather: output bit j comes from input element j/ow
    function automatic vec_t extend(vec_t s, int il, int ol, logic sgn);
        vec_t r;
        int w;
        int ow;
        int e;
        int p;
        r = '0;
        w = 8 << il;
        ow = 8 << ol;
        for (int j = 0; j < VEC_W; j++) begin
            e = j / ow;
            p = j % ow;
            if (p < w) begin
                r[j] = s[e * w + p];
            end else begin
                r[j] = sgn & s[e * w + w - 1];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] usat(logic signed [32:0] x);
        if (x < 0) begin
            return 16'h0000;
        end else if (x > $signed({17'h0, WORD_MAX})) begin
            return WORD_MAX;
        end
        return x[15:0];
    endfunction

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    rsp_t rsp_reg;
    rsp_t rsp_next;
    logic valid_reg;
    logic valid_next;
    vec_t sad_sums;
    vec_t r;
    logic [255:0] cat;
    logic [7:0] ctl;
    logic [15:0] best;
    logic [2:0] best_idx;
    logic signed [63:0] prod;

    block_sad_unit sad_u (
        .dst(req.dst),
        .src(req.src),
        .imm(req.imm),
        .sums(sad_sums)
    );

    // Next result; the control operand is only read, never written back
    always_comb begin
        rsp_next = '0;
        r = '0;
        cat = '0;
        ctl = 8'h00;
        best = 16'h0000;
        best_idx = 3'd0;
        prod = '0;
        valid_next = req_valid;
        case (req.op)
            BYTE_SHUFFLE: begin
                for (int i = 0; i < 16; i++) begin
                    ctl = req.src[i * 8 +: 8];
                    if (req.narrow && i >= 8) begin
                        r[i * 8 +: 8] = 8'h00;
                    end else if (ctl[SHUF_ZERO_BIT]) begin
                        r[i * 8 +: 8] = 8'h00;
                    end else if (req.narrow) begin
                        r[i * 8 +: 8] = req.dst[ctl[2:0] * 8 +: 8];
                    end else begin
                        r[i * 8 +: 8] = req.dst[ctl[3:0] * 8 +: 8];
                    end
                end
            end
            BYTE_ALIGN_RIGHT: begin
                // Offsets past the pair shift in zeros on their own
                if (req.narrow) begin
                    cat = {128'h0, req.dst[63:0], req.src[63:0]};
                    cat = cat >> {req.imm, 3'b000};
                    r = {64'h0, cat[63:0]};
                end else begin
                    cat = {req.dst, req.src} >> {req.imm, 3'b000};
                    r = cat[127:0];
                end
            end
            CONDITIONAL_NEGATE_B: r = cond_neg(req.dst, req.src, SZ_BYTE);
            CONDITIONAL_NEGATE_W: r = cond_neg(req.dst, req.src, SZ_WORD);
            CONDITIONAL_NEGATE_D: r = cond_neg(req.dst, req.src, SZ_DWORD);
            DWORD_MULTIPLY_LOW: begin
                for (int i = 0; i < 4; i++) begin
                    prod = $signed(req.dst[i * 32 +: 32])
                        * $signed(req.src[i * 32 +: 32]);
                    r[i * 32 +: 32] = prod[31:0];
                end
            end
            DWORD_MULTIPLY_WIDE: begin
                // Low dword of each qword lane feeds the product
                for (int i = 0; i < 2; i++) begin
                    prod = $signed(req.dst[i * 64 +: 32])
                        * $signed(req.src[i * 64 +: 32]);
                    r[i * 64 +: 64] = prod;
                end
            end
            WORD_BLEND_IMMEDIATE: begin
                for (int i = 0; i < 8; i++) begin
                    r[i * 16 +: 16] = req.imm[i] ? req.src[i * 16 +: 16]
                        : req.dst[i * 16 +: 16];
                end
            end
            BYTE_BLEND_VARIABLE: begin
                for (int i = 0; i < 16; i++) begin
                    r[i * 8 +: 8] = req.blend_mask[i * 8 + BLEND_SEL_BIT]
                        ? req.src[i * 8 +: 8] : req.dst[i * 8 +: 8];
                end
            end
            MIN_UNSIGNED_WORD: r = min_max(req.dst, req.src, SZ_WORD, 0, 0);
            MIN_UNSIGNED_DWORD: r = min_max(req.dst, req.src, SZ_DWORD, 0, 0);
            MIN_SIGNED_BYTE: r = min_max(req.dst, req.src, SZ_BYTE, 1, 0);
            MIN_SIGNED_DWORD: r = min_max(req.dst, req.src, SZ_DWORD, 1, 0);
            MAX_UNSIGNED_WORD: r = min_max(req.dst, req.src, SZ_WORD, 0, 1);
            MAX_UNSIGNED_DWORD: r = min_max(req.dst, req.src, SZ_DWORD, 0, 1);
            MAX_SIGNED_BYTE: r = min_max(req.dst, req.src, SZ_BYTE, 1, 1);
            MAX_SIGNED_DWORD: r = min_max(req.dst, req.src, SZ_DWORD, 1, 1);
            INSERT_BYTE_LANE: begin
                r = req.dst;
                r[req.imm[3:0] * 8 +: 8] = req.scalar[7:0];
            end
            INSERT_DWORD_LANE: begin
                r = req.dst;
                r[req.imm[1:0] * 32 +: 32] = req.scalar[31:0];
            end
            INSERT_QWORD_LANE: begin
                r = req.dst;
                r[req.imm[0] * 64 +: 64] = req.scalar;
            end
            // Extracted lanes are zero-extended into the scalar result
            EXTRACT_BYTE_LANE: begin
                rsp_next.scalar[7:0] = req.dst[req.imm[3:0] * 8 +: 8];
            end
            EXTRACT_WORD_LANE: begin
                rsp_next.scalar[15:0] = req.dst[req.imm[2:0] * 16 +: 16];
            end
            EXTRACT_DWORD_LANE: begin
                rsp_next.scalar[31:0] = req.dst[req.imm[1:0] * 32 +: 32];
            end
            EXTRACT_QWORD_LANE: begin
                rsp_next.scalar = req.dst[req.imm[0] * 64 +: 64];
            end
            SEXT_BYTE_TO_WORD: r = extend(req.src, 0, 1, 1'b1);
            ZEXT_BYTE_TO_WORD: r = extend(req.src, 0, 1, 1'b0);
            SEXT_BYTE_TO_DWORD: r = extend(req.src, 0, 2, 1'b1);
            ZEXT_BYTE_TO_DWORD: r = extend(req.src, 0, 2, 1'b0);
            SEXT_WORD_TO_DWORD: r = extend(req.src, 1, 2, 1'b1);
            ZEXT_WORD_TO_DWORD: r = extend(req.src, 1, 2, 1'b0);
            SEXT_BYTE_TO_QWORD: r = extend(req.src, 0, 3, 1'b1);
            ZEXT_BYTE_TO_QWORD: r = extend(req.src, 0, 3, 1'b0);
            SEXT_WORD_TO_QWORD: r = extend(req.src, 1, 3, 1'b1);
            ZEXT_WORD_TO_QWORD: r = extend(req.src, 1, 3, 1'b0);
            SEXT_DWORD_TO_QWORD: r = extend(req.src, 2, 3, 1'b1);
            ZEXT_DWORD_TO_QWORD: r = extend(req.src, 2, 3, 1'b0);
            BLOCK_ABS_DIFF_SUMS: r = sad_sums;
            HORIZONTAL_MIN_SEARCH: begin
                // Strict less-than keeps the lowest lane on a tie
                best = req.dst[15:0];
                for (int i = 1; i < 8; i++) begin
                    if (req.dst[i * 16 +: 16] < best) begin
                        best = req.dst[i * 16 +: 16];
                        best_idx = 3'(i);
                    end
                end
                r[15:0] = best;
                r[HMIN_IDX_LSB +: 3] = best_idx;
            end
            PACKED_BIT_TEST: begin
                rsp_next.zero_flag = ((req.dst & req.src) == '0);
                rsp_next.carry_flag = ((~req.src & req.dst) == '0);
            end
            QWORD_EQUAL_COMPARE: begin
                for (int i = 0; i < 2; i++) begin
                    r[i * 64 +: 64] = (req.dst[i * 64 +: 64]
                        == req.src[i * 64 +: 64]) ? '1 : '0;
                end
            end
            QWORD_GREATER_COMPARE: begin
                for (int i = 0; i < 2; i++) begin
                    r[i * 64 +: 64] = ($signed(req.dst[i * 64 +: 64])
                        > $signed(req.src[i * 64 +: 64])) ? '1 : '0;
                end
            end
            DWORD_TO_WORD_USAT_PACK: begin
                // Destination fills the low half, source the high half
                for (int e = 0; e < 4; e++) begin
                    r[e * 16 +: 16] =
                        usat(get_elem(req.dst, e, SZ_DWORD, 1'b1));
                    r[(e + 4) * 16 +: 16] =
                        usat(get_elem(req.src, e, SZ_DWORD, 1'b1));
                end
            end
            default: r = '0;
        endcase
        rsp_next.vec = r;
        if (!req_valid) begin
            rsp_next = rsp_reg;
        end
    end

    // Result stage; holds the last result while no request is issued
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            rsp_reg <= rsp_next;
            valid_reg <= valid_next;
        end
    end

    assign rsp = rsp_reg;
    assign rsp_valid = valid_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    req_t last_req;
    logic last_valid;

    // Copy of the request that produced the current result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_req <= '0;
            last_valid <= 1'b0;
        end else begin
            last_req <= req;
            last_valid <= req_valid;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Expanded inline so every operand is sampled at the same edge
    let is_op(o) = last_valid && rsp_valid && last_req.op == o;

    a_shuffle_zero: assert property (is_op(BYTE_SHUFFLE)
        && last_req.src[SHUF_ZERO_BIT] |-> rsp.vec[7:0] == 8'h00)
        else $error("shuffle byte not zeroed");
    a_shuffle_index: assert property (is_op(BYTE_SHUFFLE)
        && !last_req.src[SHUF_ZERO_BIT] && !last_req.narrow
        |-> rsp.vec[7:0] == last_req.dst[last_req.src[3:0] * 8 +: 8])
        else $error("shuffle picked wrong byte");
    a_shuffle_narrow: assert property (is_op(BYTE_SHUFFLE)
        && last_req.narrow |-> rsp.vec[127:64] == '0)
        else $error("narrow shuffle upper half not zero");
    a_negate_zero: assert property (is_op(CONDITIONAL_NEGATE_B)
        && last_req.src[7:0] == 8'h00 |-> rsp.vec[7:0] == 8'h00)
        else $error("negate with zero source not zero");
    a_mul_low: assert property (is_op(DWORD_MULTIPLY_LOW)
        |-> rsp.vec[31:0] == 32'(last_req.dst[31:0] * last_req.src[31:0]))
        else $error("low multiply wrong");
    a_mul_wide: assert property (is_op(DWORD_MULTIPLY_WIDE)
        |-> $signed(rsp.vec[63:0]) == $signed(last_req.dst[31:0])
        * $signed(last_req.src[31:0]))
        else $error("wide multiply wrong");
    a_word_blend: assert property (is_op(WORD_BLEND_IMMEDIATE)
        |-> rsp.vec[15:0] == (last_req.imm[0] ? last_req.src[15:0]
        : last_req.dst[15:0]))
        else $error("word blend wrong");
    a_hmin_pack: assert property (is_op(HORIZONTAL_MIN_SEARCH)
        |-> rsp.vec[127:19] == '0 && rsp.vec[15:0] <= last_req.dst[15:0])
        else $error("minimum search packing wrong");
    a_test_zero: assert property (is_op(PACKED_BIT_TEST)
        |-> rsp.zero_flag == ((last_req.dst & last_req.src) == '0))
        else $error("zero flag wrong");
    a_test_carry: assert property (is_op(PACKED_BIT_TEST)
        |-> rsp.carry_flag == ((~last_req.src & last_req.dst) == '0))
        else $error("carry flag wrong");
    a_eq_lane: assert property (is_op(QWORD_EQUAL_COMPARE)
        |-> rsp.vec[63:0] == ((last_req.dst[63:0] == last_req.src[63:0])
        ? 64'hFFFFFFFFFFFFFFFF : 64'h0))
        else $error("qword equal lane wrong");
    a_pack_sat: assert property (is_op(DWORD_TO_WORD_USAT_PACK)
        && last_req.dst[31] |-> rsp.vec[15:0] == 16'h0000)
        else $error("negative dword not clamped");
    a_valid_follow: assert property (req_valid |=> rsp_valid)
        else $error("result valid missing");
    // Without a request the result must sit still and valid must drop
    a_idle_hold: assert property (!req_valid |=> !rsp_valid
        && $stable(rsp))
        else $error("result moved without request");

    c_shuffle: cover property (is_op(BYTE_SHUFFLE));
    c_sad: cover property (is_op(BLOCK_ABS_DIFF_SUMS));
    c_test_both: cover property (is_op(PACKED_BIT_TEST)
        && rsp.zero_flag && rsp.carry_flag);
    c_back_to_back: cover property (req_valid [*3]);

endmodule

`default_nettype wire

// ---- logic/simd_pkg.sv ----
// Shared types and constants for the packed integer vector datapath.
// Assumes a single 20 MHz clock and an issuing pipeline that supplies
// operands, immediates and the operation code in one beat.
`default_nettype none

package simd_pkg;

    // ----------------------------------------------------------------
    // Widths and element sizes
    // ----------------------------------------------------------------
    localparam int VEC_W = 128;
    localparam int SCALAR_W = 64;
    localparam logic [1:0] SZ_BYTE = 2'd0;
    localparam logic [1:0] SZ_WORD = 2'd1;
    localparam logic [1:0] SZ_DWORD = 2'd2;

    // ----------------------------------------------------------------
    // Field positions and fixed values
    // ----------------------------------------------------------------
    localparam int SHUF_ZERO_BIT = 7;
    localparam int BLEND_SEL_BIT = 7;
    localparam int HMIN_IDX_LSB = 16;
    localparam int SAD_DST_OFF_BIT = 2;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;
    localparam int RESULT_LATENCY = 1;

    typedef logic [VEC_W-1:0] vec_t;

    // ----------------------------------------------------------------
    // Operation codes
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        NO_OPERATION,
        BYTE_SHUFFLE, BYTE_ALIGN_RIGHT,
        CONDITIONAL_NEGATE_B, CONDITIONAL_NEGATE_W, CONDITIONAL_NEGATE_D,
        DWORD_MULTIPLY_LOW, DWORD_MULTIPLY_WIDE,
        WORD_BLEND_IMMEDIATE, BYTE_BLEND_VARIABLE,
        MIN_UNSIGNED_WORD, MIN_UNSIGNED_DWORD,
        MIN_SIGNED_BYTE, MIN_SIGNED_DWORD,
        MAX_UNSIGNED_WORD, MAX_UNSIGNED_DWORD,
        MAX_SIGNED_BYTE, MAX_SIGNED_DWORD,
        INSERT_BYTE_LANE, INSERT_DWORD_LANE, INSERT_QWORD_LANE,
        EXTRACT_BYTE_LANE, EXTRACT_WORD_LANE,
        EXTRACT_DWORD_LANE, EXTRACT_QWORD_LANE,
        SEXT_BYTE_TO_WORD, ZEXT_BYTE_TO_WORD,
        SEXT_BYTE_TO_DWORD, ZEXT_BYTE_TO_DWORD,
        SEXT_WORD_TO_DWORD, ZEXT_WORD_TO_DWORD,
        SEXT_BYTE_TO_QWORD, ZEXT_BYTE_TO_QWORD,
        SEXT_WORD_TO_QWORD, ZEXT_WORD_TO_QWORD,
        SEXT_DWORD_TO_QWORD, ZEXT_DWORD_TO_QWORD,
        BLOCK_ABS_DIFF_SUMS, HORIZONTAL_MIN_SEARCH, PACKED_BIT_TEST,
        QWORD_EQUAL_COMPARE, QWORD_GREATER_COMPARE,
        DWORD_TO_WORD_USAT_PACK
    } op_t;

    // ----------------------------------------------------------------
    // Request and response carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        op_t op;
        logic narrow;
        vec_t dst;
        vec_t src;
        vec_t blend_mask;
        logic [7:0] imm;
        logic [SCALAR_W-1:0] scalar;
    } req_t;

    typedef struct packed {
        vec_t vec;
        logic [SCALAR_W-1:0] scalar;
        logic zero_flag;
        logic carry_flag;
    } rsp_t;

endpackage

`default_nettype wire

// ---- logic/block_sad_unit.sv ----
// Eight sums of absolute differences over 4-byte groups.
// Purely combinational; the caller registers the result.
`default_nettype none

module block_sad_unit (
    // Operands and group selects
    input wire simd_pkg::vec_t dst,
    input wire simd_pkg::vec_t src,
    input wire logic [7:0] imm,
    // Eight word sums
    output var simd_pkg::vec_t sums
);
    import simd_pkg::*;

    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] acc;
    int off;
    int sel;

    // Sliding 4-byte window of dst against one fixed 4-byte group of src
    always_comb begin
        sums = '0;
        a = 8'h00;
        b = 8'h00;
        acc = 16'h0000;
        off = imm[SAD_DST_OFF_BIT] ? 4 : 0;
        sel = 4 * int'(imm[1:0]);
        for (int i = 0; i < 8; i++) begin
            acc = 16'h0000;
            for (int k = 0; k < 4; k++) begin
                a = dst[(off + i + k) * 8 +: 8];
                b = src[(sel + k) * 8 +: 8];
                acc = acc + 16'((a > b) ? a - b : b - a);
            end
            sums[i * 16 +: 16] = acc;
        end
    end

endmodule

`default_nettype wire

// ---- dv/issue_model.sv ----
// Issue stage model feeding requests to the vector datapath.
// Assumes one clock; requests leave a queue that the bench fills.
`default_nettype none

module issue_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic stall,
    // Issue side
    output var logic req_valid,
    output var simd_pkg::req_t req
);
    timeunit 1ns;
    timeprecision 1ns;
    import simd_pkg::*;

    req_t q[$];

    // One request per edge unless stalled; idle operands keep moving
    // so that a stale request can never look like a fresh one
    always @(posedge clk) begin
        if (q.size() != 0 && !stall) begin
            req_valid <= 1'b1;
            req <= q.pop_front();
        end else begin
            req_valid <= 1'b0;
            req <= ~req;
        end
    end

    initial begin
        req_valid = 1'b0;
        req = '0;
    end
endmodule

`default_nettype wire

// ---- dv/simd_datapath_tb.sv ----
// Self-checking bench for the vector datapath, random plus corners.
// Assumes issue_model as the issuing side and one 20 MHz clock.
`default_nettype none

module simd_datapath_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import simd_pkg::*;

    logic clk, rst_n, stall, req_valid, rsp_valid;
    req_t req, r;
    rsp_t rsp;
    rsp_t exp_q[$];
    int mismatches = 0, checks_done = 0, seed = 6747;
    op_t ops[12] = '{BYTE_SHUFFLE, CONDITIONAL_NEGATE_B,
        DWORD_MULTIPLY_LOW, DWORD_MULTIPLY_WIDE, MIN_SIGNED_BYTE,
        HORIZONTAL_MIN_SEARCH, PACKED_BIT_TEST, QWORD_EQUAL_COMPARE,
        QWORD_GREATER_COMPARE, DWORD_TO_WORD_USAT_PACK,
        WORD_BLEND_IMMEDIATE, EXTRACT_DWORD_LANE};

    issue_model i_issue_model (.clk(clk), .stall(stall),
        .req_valid(req_valid), .req(req));
    simd_datapath i_simd_datapath (.clk(clk), .rst_n(rst_n),
        .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
        .rsp(rsp));

    // ----------------------------------------
    // Expected results
    // ----------------------------------------
    function automatic rsp_t model(req_t x);
        rsp_t e;
        logic [7:0] c;
        logic signed [31:0] a, b;
        e = '0;
        case (x.op)
            BYTE_SHUFFLE:
                for (int i = 0; i < 16; i++) begin
                    c = x.src[8*i+:8];
                    e.vec[8*i+:8] = (c[7] || (x.narrow && i > 7)) ? 8'h00
                        : x.dst[8*(x.narrow ? c[2:0] : c[3:0])+:8];
                end
            CONDITIONAL_NEGATE_B:
                for (int i = 0; i < 16; i++) begin
                    c = x.src[8*i+:8];
                    e.vec[8*i+:8] = c[7] ? -x.dst[8*i+:8] :
                        (c == 8'h00) ? 8'h00 : x.dst[8*i+:8];
                end
            DWORD_MULTIPLY_LOW, DWORD_MULTIPLY_WIDE:
                for (int i = 0; i < 4; i++) begin
                    a = x.dst[32*i+:32];
                    b = x.src[32*i+:32];
                    if (x.op == DWORD_MULTIPLY_LOW)
                        e.vec[32*i+:32] = a * b;
                    else if (i % 2 == 0)
                        e.vec[32*i+:64] = 64'(a) * 64'(b);
                end
            MIN_SIGNED_BYTE:
                for (int i = 0; i < 16; i++)
                    e.vec[8*i+:8] = $signed(x.dst[8*i+:8]) <
                        $signed(x.src[8*i+:8]) ? x.dst[8*i+:8] :
                        x.src[8*i+:8];
            HORIZONTAL_MIN_SEARCH: begin
                e.vec[15:0] = x.dst[15:0];
                for (int i = 1; i < 8; i++)
                    if (x.dst[16*i+:16] < e.vec[15:0]) begin
                        e.vec[15:0] = x.dst[16*i+:16];
                        e.vec[18:16] = 3'(i);
                    end
            end
            WORD_BLEND_IMMEDIATE:
                for (int i = 0; i < 8; i++)
                    e.vec[16*i+:16] = x.imm[i] ? x.src[16*i+:16] :
                        x.dst[16*i+:16];
            EXTRACT_DWORD_LANE:
                e.scalar[31:0] = x.dst[32*x.imm[1:0]+:32];
            PACKED_BIT_TEST: begin
                e.zero_flag = (x.dst & x.src) == '0;
                e.carry_flag = (x.dst & ~x.src) == '0;
            end
            QWORD_EQUAL_COMPARE, QWORD_GREATER_COMPARE:
                for (int i = 0; i < 2; i++)
                    e.vec[64*i+:64] = {64{x.op == QWORD_EQUAL_COMPARE ?
                        x.dst[64*i+:64] == x.src[64*i+:64] :
                        $signed(x.dst[64*i+:64]) >
                        $signed(x.src[64*i+:64])}};
            DWORD_TO_WORD_USAT_PACK:
                for (int i = 0; i < 8; i++) begin
                    a = i < 4 ? x.dst[32*i+:32] : x.src[32*(i-4)+:32];
                    e.vec[16*i+:16] = a < 0 ? 16'h0000 :
                        a > 32'sh0000FFFF ? WORD_MAX : a[15:0];
                end
            default: ;
        endcase
        return e;
    endfunction

    function automatic req_t rnd(op_t op);
        req_t x;
        x = '0;
        x.op = op;
        x.imm = 8'($random(seed));
        for (int i = 0; i < 4; i++) begin
            x.dst[32*i+:32] = $random(seed);
            x.src[32*i+:32] = $random(seed);
        end
        return x;
    endfunction

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input string nm, input rsp_t e, input rsp_t g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic add(input req_t x);
        i_issue_model.q.push_back(x);
        exp_q.push_back(model(x));
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Random stalls make the issue side both prompt and slow
    always @(posedge clk)
        stall <= ($random(seed) % 3) == 0;

    // Every result pulse must match the oldest outstanding request
    always @(negedge clk)
        if (rsp_valid === 1'b1)
            chk("response", exp_q.size() ? exp_q.pop_front() : ~rsp, rsp);

    // Main sequence
    initial begin
        rst_n = 1'b0;
        stall = 1'b0;
        repeat (6) @(posedge clk);
        chk("reset rsp", '0, rsp);
        chk("reset valid", '0, {193'h0, rsp_valid});
        $display("reset test done");
        rst_n <= 1'b1;
        r = rnd(BYTE_SHUFFLE);
        r.src = {8{16'h8F0F}};
        add(r);
        r.narrow = 1'b1;
        add(r);
        r = rnd(CONDITIONAL_NEGATE_B);
        r.src[63:0] = '0;
        add(r);
        r = rnd(DWORD_TO_WORD_USAT_PACK);
        r.dst = {32'hFFFFFFFF, 32'h00010000, 32'h0000FFFF, 32'h00000000};
        add(r);
        r = rnd(PACKED_BIT_TEST);
        r.dst = '0;
        add(r);
        r.dst = r.src;
        add(r);
        r = rnd(QWORD_EQUAL_COMPARE);
        r.src = r.dst ^ {1'b1, 127'h0};
        add(r);
        r = rnd(HORIZONTAL_MIN_SEARCH);
        r.dst = {{4{16'h0001}}, {4{16'h0005}}};
        add(r);
        r = rnd(QWORD_GREATER_COMPARE);
        r.dst = {64'h8000000000000000, 64'h0000000000000001};
        r.src = '0;
        add(r);
        r = rnd(DWORD_MULTIPLY_WIDE);
        r.dst = {4{32'h80000000}};
        add(r);
        for (int n = 0; n < 40; n++)
            foreach (ops[k]) add(rnd(ops[k]));
        for (int t = 0; t < 5000 && exp_q.size() != 0; t++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        if (exp_q.size() != 0)
            mismatches++;
        $display("random test done");
        give_verdict();
    end

    // Watchdog well past the expected run length
    initial begin
        #2000000;
        mismatches++;
        give_verdict();
    end
endmodule

`default_nettype wire
